// ### tes_core_model.sv
// Behavioural model of the fetch pipeline that feeds the trap entry sequencer
`timescale 1ns/1ps
module tes_core_model (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic redirect_in,
  input wire logic halted_in,
  input wire logic [31:0] fetch_pc_in,
  input wire logic [31:0] fetch_next_pc_in,
  output logic [31:0] pc_out,
  output logic [31:0] next_pc_out
);
  import tes_pkg::*;
  // Counters step one word a cycle, follow a redirect, freeze while halted
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_out <= 32'h0000_0100;
      next_pc_out <= 32'h0000_0104;
    end else if (redirect_in) begin
      pc_out <= fetch_pc_in;
      next_pc_out <= fetch_next_pc_in;
    end else if (!halted_in) begin
      pc_out <= next_pc_out;
      next_pc_out <= next_pc_out + TES_PC_STEP;
    end
  end
endmodule : tes_core_model

// ### tes_pkg.sv
// Package of constants and types for the trap entry sequencer
package tes_pkg;
  localparam int TES_WIN_BITS = 3;
  localparam logic [7:0] TES_TT_STORE_FAULT = 8'h2B;
  localparam logic [7:0] TES_TT_FETCH_MISS = 8'h3C;
  localparam logic [7:0] TES_TT_FETCH_FAULT = 8'h21;
  localparam logic [7:0] TES_TT_REG_FAULT = 8'h20;
  localparam logic [7:0] TES_TT_FETCH_EXC = 8'h01;
  localparam logic [31:0] TES_RESET_PC = 32'h0000_0000;
  localparam logic [31:0] TES_PC_STEP = 32'h0000_0004;
  localparam logic [4:0] TES_SAVE_PC_REG = 5'h11;
  localparam logic [4:0] TES_SAVE_NPC_REG = 5'h12;
  localparam int TES_PRIO_BITS = 5;
  localparam logic [4:0] TES_PRIO_NONE = 5'h1F;
  typedef enum logic [2:0] {
    TES_RUN = 3'b001,
    TES_SAVE = 3'b010,
    TES_HALT = 3'b100
  } tes_state_t;
endpackage : tes_pkg

// ### tes_trap_entry_sequencer.sv
// Trap entry sequencer: state word update, counter save, fetch redirect
`timescale 1ns/1ps
module tes_trap_entry_sequencer #(
  parameter int WINDOW_COUNT = 8
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic reset_req_in,
  input wire logic store_fault_in,
  input wire logic fetch_miss_in,
  input wire logic fetch_fault_in,
  input wire logic reg_fault_in,
  input wire logic fetch_exc_in,
  input wire logic precise_req_in,
  input wire logic [7:0] precise_tt_in,
  input wire logic [4:0] precise_prio_in,
  input wire logic async_req_in,
  input wire logic [7:0] async_tt_in,
  input wire logic [4:0] async_prio_in,
  input wire logic [31:0] pc_in,
  input wire logic [31:0] next_pc_in,
  input wire logic [31:0] trap_base_in,
  input wire logic [tes_pkg::TES_WIN_BITS-1:0] window_init_in,
  output logic trap_enable_out,
  output logic supervisor_out,
  output logic previous_supervisor_out,
  output logic [tes_pkg::TES_WIN_BITS-1:0] current_window_pointer_out,
  output logic [7:0] trap_type_field_out,
  output logic redirect_out,
  output logic [31:0] fetch_pc_out,
  output logic [31:0] fetch_next_pc_out,
  output logic reg_wr_out,
  output logic [tes_pkg::TES_WIN_BITS-1:0] reg_wr_window_out,
  output logic [4:0] reg_wr_addr_out,
  output logic [31:0] reg_wr_data_out,
  output logic halted_out,
  output logic trap_taken_out
);
  import tes_pkg::*;

  // ---------------------------------------------------------------
  // Input synchroniser for reset request
  // ---------------------------------------------------------------
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= reset_req_in;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Trap classification and priority
  // ---------------------------------------------------------------
  wire fault_any;
  wire [7:0] fault_tt;
  wire [4:0] fault_prio;
  wire [7:0] prec_tt;
  wire [4:0] prec_prio;
  wire prec_any;
  wire async_wins;
  wire [7:0] win_tt;
  wire is_precise;
  assign fault_any = store_fault_in | fetch_miss_in | fetch_fault_in | reg_fault_in |
                     fetch_exc_in;
  assign fault_tt = store_fault_in ? TES_TT_STORE_FAULT :
                    fetch_miss_in ? TES_TT_FETCH_MISS :
                    fetch_fault_in ? TES_TT_FETCH_FAULT :
                    reg_fault_in ? TES_TT_REG_FAULT :
                    TES_TT_FETCH_EXC;
  assign fault_prio = (store_fault_in | fetch_miss_in) ? 5'h02 :
                      fetch_fault_in ? 5'h03 : reg_fault_in ? 5'h04 : 5'h05;
  // Fault sources compete with the pipeline's own precise request
  assign prec_any = fault_any | precise_req_in;
  assign prec_prio = !fault_any ? precise_prio_in :
                     (precise_req_in && precise_prio_in < fault_prio) ? precise_prio_in :
                     fault_prio;
  assign prec_tt = !fault_any ? precise_tt_in :
                   (precise_req_in && precise_prio_in < fault_prio) ? precise_tt_in :
                   fault_tt;
  assign async_wins = async_req_in && (!prec_any || async_prio_in < prec_prio);
  assign is_precise = prec_any && !async_wins;
  assign win_tt = async_wins ? async_tt_in : prec_tt;

  wire [TES_WIN_BITS-1:0] new_cwp;
  assign new_cwp = (current_window_pointer_out == '0) ?
                   TES_WIN_BITS'(WINDOW_COUNT - 1) :
                   current_window_pointer_out - 1'b1;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  tes_state_t state_reg;
  tes_state_t state_next;
  wire take_reset;
  wire take_trap;
  wire go_halt;
  assign take_reset = rst_sync2_reg;
  assign take_trap = (state_reg == TES_RUN) && trap_enable_out && (prec_any || async_req_in);
  // Ignored async requests must not mask a precise trap
  assign go_halt = (state_reg == TES_RUN) && !trap_enable_out && prec_any;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TES_RUN: begin
        if (take_reset || take_trap) begin
          state_next = TES_SAVE;
        end else if (go_halt) begin
          state_next = TES_HALT;
        end
      end
      TES_SAVE: begin
        state_next = take_reset ? TES_SAVE : TES_RUN;
      end
      TES_HALT: begin
        state_next = take_reset ? TES_SAVE : TES_HALT;
      end
      default: begin
        state_next = TES_RUN;
      end
    endcase
  end

  logic [31:0] saved_npc_reg;
  wire enter;
  assign enter = (state_reg != TES_SAVE) && (take_reset || take_trap);

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= TES_RUN;
      trap_enable_out <= 1'b0;
      supervisor_out <= 1'b1;
      previous_supervisor_out <= 1'b0;
      current_window_pointer_out <= '0;
      trap_type_field_out <= 8'h00;
      redirect_out <= 1'b0;
      fetch_pc_out <= TES_RESET_PC;
      fetch_next_pc_out <= TES_PC_STEP;
      reg_wr_out <= 1'b0;
      reg_wr_window_out <= '0;
      reg_wr_addr_out <= 5'h00;
      reg_wr_data_out <= 32'h0000_0000;
      saved_npc_reg <= 32'h0000_0000;
      halted_out <= 1'b0;
      trap_taken_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      redirect_out <= 1'b0;
      reg_wr_out <= 1'b0;
      trap_taken_out <= 1'b0;
      halted_out <= (state_next == TES_HALT);
      if (enter) begin
        // Counters, state word and window change together
        trap_enable_out <= 1'b0;
        previous_supervisor_out <= supervisor_out;
        supervisor_out <= 1'b1;
        current_window_pointer_out <= new_cwp;
        if (!take_reset) begin
          trap_type_field_out <= win_tt;
        end
        redirect_out <= 1'b1;
        trap_taken_out <= 1'b1;
        fetch_pc_out <= take_reset ? TES_RESET_PC : trap_base_in;
        fetch_next_pc_out <= take_reset ? TES_PC_STEP : trap_base_in + TES_PC_STEP;
        reg_wr_out <= 1'b1;
        reg_wr_window_out <= new_cwp;
        reg_wr_addr_out <= TES_SAVE_PC_REG;
        reg_wr_data_out <= pc_in;
        saved_npc_reg <= next_pc_in;
      end else if (state_reg == TES_SAVE) begin
        reg_wr_out <= 1'b1;
        reg_wr_addr_out <= TES_SAVE_NPC_REG;
        reg_wr_data_out <= saved_npc_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_entry;
    trap_taken_out ##0 reg_wr_out ##0 (reg_wr_addr_out == TES_SAVE_PC_REG);
  endsequence
  sequence s_second;
    reg_wr_out ##0 (reg_wr_addr_out == TES_SAVE_NPC_REG);
  endsequence

  chk_entry_disables: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    trap_taken_out |-> !trap_enable_out && supervisor_out)
    else $error("trap entry left traps enabled or not supervisor");
  chk_ps_copy: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    enter |=> previous_supervisor_out == $past(supervisor_out))
    else $error("previous supervisor not copied");
  chk_cwp_dec: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    enter |=> current_window_pointer_out ==
      TES_WIN_BITS'(($past(current_window_pointer_out) + WINDOW_COUNT - 1) % WINDOW_COUNT))
    else $error("window pointer not decremented");
  chk_save_pair: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_entry |=> s_second)
    else $error("next counter not saved after counter");
  chk_reset_vec: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (enter && take_reset) |=> fetch_pc_out == TES_RESET_PC && fetch_next_pc_out == TES_PC_STEP)
    else $error("reset trap vector wrong");
  chk_base_vec: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (enter && !take_reset) |=> fetch_pc_out == $past(trap_base_in) &&
      fetch_next_pc_out == $past(trap_base_in) + TES_PC_STEP)
    else $error("trap base vector wrong");
  chk_tt_reset: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (enter && take_reset) |=> $stable(trap_type_field_out))
    else $error("reset trap changed trap type");
  chk_halt_entry: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    go_halt && !take_reset |=> halted_out && $stable(current_window_pointer_out))
    else $error("precise trap with traps off did not halt");
  chk_halt_stay: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    halted_out && !take_reset |=> halted_out && !trap_taken_out)
    else $error("left halted state without reset");
  chk_async_ignore: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (!trap_enable_out && !prec_any && !take_reset) |=> !trap_taken_out)
    else $error("interrupt taken while traps disabled");

  // ---------------------------------------------------------------
  // Classification and sequencing checks
  // ---------------------------------------------------------------
  sequence s_quiet;
    !reg_wr_out ##0 !redirect_out ##0 !trap_taken_out;
  endsequence

  chk_store_class: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    store_fault_in |-> fault_tt == TES_TT_STORE_FAULT)
    else $error("store fault classified wrongly");
  chk_miss_class: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (!store_fault_in && fetch_miss_in) |-> fault_tt == TES_TT_FETCH_MISS)
    else $error("fetch miss classified wrongly");
  chk_ifault_class: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (!store_fault_in && !fetch_miss_in && fetch_fault_in) |->
      fault_tt == TES_TT_FETCH_FAULT)
    else $error("fetch fault classified wrongly");
  chk_rfault_class: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (!store_fault_in && !fetch_miss_in && !fetch_fault_in && reg_fault_in) |->
      fault_tt == TES_TT_REG_FAULT)
    else $error("register fault classified wrongly");
  chk_fexc_class: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (!store_fault_in && !fetch_miss_in && !fetch_fault_in && !reg_fault_in &&
      fetch_exc_in) |-> fault_tt == TES_TT_FETCH_EXC)
    else $error("fetch exception classified wrongly");
  chk_te_gate: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (state_reg == TES_RUN && !trap_enable_out && !take_reset) |=> !trap_taken_out)
    else $error("trap entered with traps disabled");
  chk_te_stays: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !trap_enable_out |=> !trap_enable_out)
    else $error("trap enable set by sequencer");
  chk_halt_quiet: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (go_halt && !take_reset) |=> s_quiet ##0 ($stable(trap_enable_out) &&
      $stable(supervisor_out) && $stable(trap_type_field_out)))
    else $error("halt entry changed state");
  chk_halt_async: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (state_reg == TES_RUN && !trap_enable_out && prec_any && !take_reset) |=> halted_out)
    else $error("precise trap masked by ignored request");
  chk_s_set: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    enter |=> supervisor_out)
    else $error("supervisor not set on entry");
  chk_pulse_once: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    trap_taken_out |=> !trap_taken_out && !redirect_out)
    else $error("entry pulse longer than one cycle");
  chk_win_match: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    reg_wr_out |-> reg_wr_window_out == current_window_pointer_out)
    else $error("save written outside new window");
  chk_pc_saved: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    enter |=> reg_wr_data_out == $past(pc_in))
    else $error("trapped counter not saved");
  chk_npc_saved: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    enter ##1 1'b1 |=> reg_wr_data_out == $past(next_pc_in, 2))
    else $error("trapped next counter not saved");
  chk_async_loses: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (async_req_in && prec_any && async_prio_in >= prec_prio) |-> is_precise)
    else $error("lower priority request won");
  chk_reset_start: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (enter && take_reset) |=> redirect_out && trap_taken_out)
    else $error("reset trap did not redirect fetch");
endmodule : tes_trap_entry_sequencer

// ### tes_trap_entry_sequencer_bench.sv
// Self-checking bench for the trap entry sequencer
`timescale 1ns/1ps
module tes_trap_entry_sequencer_bench;
  import tes_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic reset_req_in = 1'b0;
  logic async_req_in = 1'b0;
  logic [5:0] fault_vec = 6'h00;
  logic [7:0] async_tt_in = 8'h00, precise_tt_in = 8'h03, trap_type_field_out;
  logic [4:0] async_prio_in = 5'h1F, precise_prio_in = 5'h06, reg_wr_addr_out;
  logic [TES_WIN_BITS-1:0] current_window_pointer_out, reg_wr_window_out, exp_cwp;
  logic [31:0] fetch_pc_out, fetch_next_pc_out, reg_wr_data_out, pc_in, next_pc_in, pc_h1, npc_h1;
  logic trap_enable_out, supervisor_out, previous_supervisor_out, redirect_out;
  logic reg_wr_out, halted_out, trap_taken_out;
  int n_mismatch = 0, comparisons = 0, cycles = 0, n_taken = 0, exp_taken = 0;
  tes_trap_entry_sequencer tes_trap_entry_sequencer_inst (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .reset_req_in(reset_req_in),
    .store_fault_in(fault_vec[0]), .fetch_miss_in(fault_vec[1]), .fetch_fault_in(fault_vec[2]),
    .reg_fault_in(fault_vec[3]), .fetch_exc_in(fault_vec[4]), .precise_req_in(fault_vec[5]),
    .precise_tt_in(precise_tt_in), .precise_prio_in(precise_prio_in),
    .async_req_in(async_req_in), .async_tt_in(async_tt_in), .async_prio_in(async_prio_in),
    .pc_in(pc_in), .next_pc_in(next_pc_in), .trap_base_in(32'h0000_4000),
    .window_init_in(3'h5), .trap_enable_out(trap_enable_out), .supervisor_out(supervisor_out),
    .previous_supervisor_out(previous_supervisor_out),
    .current_window_pointer_out(current_window_pointer_out),
    .trap_type_field_out(trap_type_field_out), .redirect_out(redirect_out),
    .fetch_pc_out(fetch_pc_out), .fetch_next_pc_out(fetch_next_pc_out),
    .reg_wr_out(reg_wr_out), .reg_wr_window_out(reg_wr_window_out),
    .reg_wr_addr_out(reg_wr_addr_out), .reg_wr_data_out(reg_wr_data_out),
    .halted_out(halted_out), .trap_taken_out(trap_taken_out));
  tes_core_model tes_core_model_inst (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .redirect_in(redirect_out),
    .halted_in(halted_out), .fetch_pc_in(fetch_pc_out), .fetch_next_pc_in(fetch_next_pc_out),
    .pc_out(pc_in), .next_pc_out(next_pc_in));
  initial begin
    forever #2 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    pc_h1 <= pc_in;
    npc_h1 <= next_pc_in;
    if (trap_taken_out === 1'b1) n_taken++;
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic reset_trap();
    logic [31:0] exp_npc;
    int k;
    @(posedge core_clk_in);
    reset_req_in <= 1'b1;
    @(posedge core_clk_in);
    reset_req_in <= 1'b0;
    #1;
    k = 0;
    while (trap_taken_out !== 1'b1 && k < 10) begin
      @(posedge core_clk_in);
      #1;
      k++;
    end
    exp_cwp = exp_cwp - 3'h1;
    exp_taken++;
    exp_npc = npc_h1;
    check("taken", 1'b1, trap_taken_out);
    check("redirect", 1'b1, redirect_out);
    check("fetch pc", TES_RESET_PC, fetch_pc_out);
    check("fetch next pc", TES_RESET_PC + TES_PC_STEP, fetch_next_pc_out);
    check("trap enable", 1'b0, trap_enable_out);
    check("supervisor", 1'b1, supervisor_out);
    check("prev supervisor", 1'b1, previous_supervisor_out);
    check("window", exp_cwp, current_window_pointer_out);
    check("trap type", 8'h00, trap_type_field_out);
    check("halted", 1'b0, halted_out);
    check("wr pc", 1'b1, reg_wr_out);
    check("wr pc addr", TES_SAVE_PC_REG, reg_wr_addr_out);
    check("wr pc window", exp_cwp, reg_wr_window_out);
    check("wr pc data", pc_h1, reg_wr_data_out);
    @(posedge core_clk_in);
    #1;
    check("wr npc", 1'b1, reg_wr_out);
    check("wr npc addr", TES_SAVE_NPC_REG, reg_wr_addr_out);
    check("wr npc window", exp_cwp, reg_wr_window_out);
    check("wr npc data", exp_npc, reg_wr_data_out);
  endtask : reset_trap
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    exp_cwp = 3'h0;
    repeat (20) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(posedge core_clk_in);
    #1;
    check("reset trap enable", 1'b0, trap_enable_out);
    check("reset supervisor", 1'b1, supervisor_out);
    check("reset window", 3'h0, current_window_pointer_out);
    @(posedge core_clk_in);
    async_req_in <= 1'b1;
    async_tt_in <= 8'h1F;
    async_prio_in <= 5'h01;
    repeat (4) @(posedge core_clk_in);
    async_req_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1;
    check("async taken", exp_taken, n_taken);
    check("async halted", 1'b0, halted_out);
    reset_trap();
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk_in);
      fault_vec <= 6'h01 << i;
      async_req_in <= 1'b1;
      @(posedge core_clk_in);
      fault_vec <= 6'h00;
      async_req_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
      #1;
      check("halted", 1'b1, halted_out);
      check("halt taken", exp_taken, n_taken);
      check("halt window", exp_cwp, current_window_pointer_out);
      check("halt trap type", 8'h00, trap_type_field_out);
      reset_trap();
    end
    summarize();
  end
endmodule : tes_trap_entry_sequencer_bench
